// ===== rtl/vsdp_pkg.sv
/*
 Shared constants, layouts and helper functions of the voice serial data
 port: register layouts, reset values, slot and strobe timing counts.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package vsdp_pkg;

  localparam int SLOT_BITS = 8;
  localparam int STROBE_BITS = 16;
  localparam int CNT_W = 10;
  localparam int PORT_CFG_W = 8;
  localparam int CHAN_ONE_W = 14;
  localparam int CHAN_TWO_W = 10;
  localparam int REG_PORT = 0;
  localparam int REG_CHAN_ONE = 1;
  localparam int REG_CHAN_TWO = 2;
  localparam logic [7:0] PORT_CFG_RST = 8'h00;
  localparam logic [13:0] CHAN_CFG_RST = 14'h0000;
  localparam logic [3:0] STROBE_LAST = 4'hf;

  typedef struct packed {
    logic enable;
    logic dblClk;
    logic [5:0] slotsPerFrame;
  } vsdp_port_cfg_t;

  typedef struct packed {
    logic [3:0] rxPulseIndex;
    logic compandingLawSel;
    logic linear;
    logic dataDirection;
    logic [5:0] firstSlot;
    logic enable;
  } vsdp_chan_cfg_t;

  typedef struct packed {
    vsdp_port_cfg_t port;
    vsdp_chan_cfg_t one;
    vsdp_chan_cfg_t two;
    logic strobed;
  } vsdp_link_cfg_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SEND = 2'b10
  } vsdp_tx_state_t;

  // {hit, second slot of a linear pair}; slots past the frame never hit
  function automatic logic [1:0] vsdp_chan_hit(input vsdp_chan_cfg_t c,
                                              input logic [5:0] slot,
                                              input logic [5:0] nSlots);
    logic first;
    logic second;
    first = c.enable && (slot < nSlots) && (slot == c.firstSlot);
    second = c.enable && c.linear && (slot < nSlots) &&
             (slot == 6'(c.firstSlot + 6'h01));
    return {first | second, second};
  endfunction

  // msb first; linear puts bits 15..8 in the first slot, 7..0 in the next
  function automatic logic [3:0] vsdp_bit_index(input logic linear,
                                                input logic second,
                                                input logic [2:0] b);
    return {linear & ~second, ~b};
  endfunction

endpackage

// ===== rtl/vsdp_toggle_sync.sv
/*
 Toggle event crossing: three flip-flops into the destination clock and a
 one-cycle pulse once the second and third stages agree on a new level.
 Assumes the source toggles no faster than every few destination cycles.
*/
`timescale 1ns/10ps
`default_nettype none

module vsdp_toggle_sync (
  input wire logic clk,
  input wire logic rstn,
  input wire logic togIn,
  output logic pulse
);

  logic s1;
  logic s2;
  logic s3;
  logic seen;
  wire logic settled = (s2 == s3) && (s3 != seen);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      seen <= 1'b0;
      pulse <= 1'b0;
    end else begin
      s1 <= togIn;
      s2 <= s1;
      s3 <= s2;
      if (settled) begin
        seen <= s3;
      end
      pulse <= settled;
    end
  end

endmodule

`default_nettype wire

// ===== rtl/vsdp_port.sv
/*
 Voice serial data port: time-slot bus (single or double clock mode, two
 channels) or strobed serial interface, sharing the data pins.
 Assumes the far end supplies bitClock and frameSync, and that the control
 interface elsewhere writes the three configuration registers.
*/
`timescale 1ns/10ps
`default_nettype none

module vsdp_port
  import vsdp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic bitClock,
  input wire logic frameSync,
  input wire logic strobedSel,
  input wire logic [2:0] cfgWrite,
  input wire logic [13:0] cfgData,
  input wire logic [15:0] txWordOne,
  input wire logic [15:0] txWordTwo,
  input wire logic dataLineAIn,
  output logic dataLineAOut,
  output logic dataLineAOe,
  input wire logic dataLineBIn,
  output logic dataLineBOut,
  output logic dataLineBOe,
  input wire logic rxStrobe,
  output logic txStrobe,
  output logic [PORT_CFG_W-1:0] serialPortConfig,
  output logic [CHAN_ONE_W-1:0] voiceChannelOneConfig,
  output logic [CHAN_TWO_W-1:0] voiceChannelTwoConfig,
  output logic [15:0] rxWordOne,
  output logic [15:0] rxWordTwo,
  output logic rxValid
);

  //////////////////////////////////////////////////////////////////////////
  // reference clock side: registers, hold words, frame event

  vsdp_link_cfg_t cfgHold;
  logic [15:0] txHoldOne;
  logic [15:0] txHoldTwo;
  logic fsTogN;
  logic frameEvt;
  logic [15:0] rxHeldOne;
  logic [15:0] rxHeldTwo;

  vsdp_toggle_sync frameSyncer (
    .clk(ref_clk),
    .rstn(rstn),
    .togIn(fsTogN),
    .pulse(frameEvt)
  );

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      serialPortConfig <= PORT_CFG_RST;
      voiceChannelOneConfig <= CHAN_CFG_RST;
      voiceChannelTwoConfig <= CHAN_CFG_RST[CHAN_TWO_W-1:0];
    end else begin
      if (cfgWrite[REG_PORT]) begin
        serialPortConfig <= cfgData[PORT_CFG_W-1:0];
      end
      if (cfgWrite[REG_CHAN_ONE]) begin
        voiceChannelOneConfig <= cfgData;
      end
      if (cfgWrite[REG_CHAN_TWO]) begin
        voiceChannelTwoConfig <= cfgData[CHAN_TWO_W-1:0];
      end
    end
  end

  // hold words change only just after a frame start, so the link side
  // samples them at the next frame start long after they settled
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cfgHold <= '0;
      txHoldOne <= 16'h0000;
      txHoldTwo <= 16'h0000;
    end else if (frameEvt) begin
      cfgHold <= {serialPortConfig, voiceChannelOneConfig,
                  4'h0, voiceChannelTwoConfig, strobedSel};
      txHoldOne <= txWordOne;
      txHoldTwo <= txWordTwo;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rxWordOne <= 16'h0000;
      rxWordTwo <= 16'h0000;
      rxValid <= 1'b0;
    end else begin
      rxValid <= frameEvt && cfgHold.port.enable;
      if (frameEvt) begin
        rxWordOne <= rxHeldOne;
        rxWordTwo <= rxHeldTwo;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // link side, falling edge: frame timing and sampling

  vsdp_link_cfg_t linkCfg;
  logic [15:0] linkTxOne;
  logic [15:0] linkTxTwo;
  logic fsPrev;
  logic [CNT_W-1:0] cnt;
  logic [15:0] rxShiftOne;
  logic [15:0] rxShiftTwo;
  logic [15:0] ssShift;
  logic rxStrobePrev;
  logic [4:0] pulseNum;

  wire logic fsRise = frameSync & ~fsPrev;
  wire logic dbl = linkCfg.port.dblClk;
  wire logic [5:0] nSlots = linkCfg.port.slotsPerFrame;
  wire logic [CNT_W-1:0] frameLen = dbl ? {nSlots, 4'h0} :
                                          {1'b0, nSlots, 3'h0};
  wire logic [CNT_W-1:0] cntInc = CNT_W'(cnt + 1'b1);
  wire logic [CNT_W-1:0] next_cnt = fsRise ? CNT_W'(1) :
                                    (cntInc >= frameLen) ? '0 : cntInc;
  wire logic [8:0] bitIdx = dbl ? cnt[9:1] : cnt[8:0];
  wire logic [5:0] slot = bitIdx[8:3];
  wire logic [2:0] bitInSlot = bitIdx[2:0];
  wire logic slotInRange = slot < nSlots;
  wire logic slotActive = linkCfg.port.enable && !linkCfg.strobed;
  wire logic ssActive = linkCfg.port.enable && linkCfg.strobed;
  wire logic sampleNow = !dbl || cnt[0];
  wire logic driveNow = !dbl || !cnt[0];
  wire logic [1:0] hitOne = vsdp_chan_hit(linkCfg.one, slot, nSlots);
  wire logic [1:0] hitTwo = vsdp_chan_hit(linkCfg.two, slot, nSlots);
  wire logic rxBitOne = linkCfg.one.dataDirection ? dataLineAIn : dataLineBIn;
  wire logic rxBitTwo = linkCfg.two.dataDirection ? dataLineAIn : dataLineBIn;
  // companded words land in the low byte, upper byte reads zero
  wire logic [15:0] heldOne = linkCfg.one.linear ? rxShiftOne :
                              {8'h00, rxShiftOne[7:0]};
  wire logic [15:0] heldTwo = linkCfg.two.linear ? rxShiftTwo :
                              {8'h00, rxShiftTwo[7:0]};
  wire logic strobeRise = rxStrobe & ~rxStrobePrev;
  wire logic [4:0] curNum = 5'(pulseNum + {4'h0, strobeRise});
  wire logic [4:0] wantNum = 5'({1'b0, linkCfg.one.rxPulseIndex} + 5'h01);
  // receive side relies on the far end's pulses being 16 clocks long
  wire logic ssTake = ssActive && rxStrobe && (curNum == wantNum);

  always_ff @(negedge bitClock or negedge rstn) begin
    if (!rstn) begin
      fsPrev <= 1'b0;
      cnt <= '0;
      fsTogN <= 1'b0;
    end else begin
      fsPrev <= frameSync;
      cnt <= next_cnt;
      if (fsRise) begin
        fsTogN <= ~fsTogN;
      end
    end
  end

  always_ff @(negedge bitClock or negedge rstn) begin
    if (!rstn) begin
      linkCfg <= '0;
      linkTxOne <= 16'h0000;
      linkTxTwo <= 16'h0000;
      rxHeldOne <= 16'h0000;
      rxHeldTwo <= 16'h0000;
    end else if (fsRise) begin
      linkCfg <= cfgHold;
      linkTxOne <= txHoldOne;
      linkTxTwo <= txHoldTwo;
      rxHeldOne <= linkCfg.strobed ? ssShift : heldOne;
      rxHeldTwo <= heldTwo;
    end
  end

  always_ff @(negedge bitClock or negedge rstn) begin
    if (!rstn) begin
      rxShiftOne <= 16'h0000;
      rxShiftTwo <= 16'h0000;
    end else if (slotActive && sampleNow) begin
      if (hitOne[1]) begin
        rxShiftOne <= {rxShiftOne[14:0], rxBitOne};
      end
      if (hitTwo[1]) begin
        rxShiftTwo <= {rxShiftTwo[14:0], rxBitTwo};
      end
    end
  end

  // receiver: own pulse count, untouched by the transmitter
  always_ff @(negedge bitClock or negedge rstn) begin
    if (!rstn) begin
      rxStrobePrev <= 1'b0;
      pulseNum <= 5'h00;
      ssShift <= 16'h0000;
    end else begin
      rxStrobePrev <= rxStrobe;
      if (fsRise) begin
        pulseNum <= {4'h0, strobeRise};
      end else if (strobeRise && pulseNum != 5'h1f) begin
        pulseNum <= curNum;
      end
      if (ssTake) begin
        ssShift <= {ssShift[14:0], dataLineBIn};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // link side, rising edge: driving the lines

  vsdp_tx_state_t txState;
  vsdp_tx_state_t next_txState;
  logic [3:0] bitLeft;
  logic [3:0] next_bitLeft;
  logic fsTogP;
  logic next_dataLineAOut;
  logic next_dataLineAOe;
  logic next_dataLineBOut;
  logic next_dataLineBOe;
  logic next_txStrobe;

  wire logic startSeen = fsTogN != fsTogP;
  wire logic oneOnA = hitOne[1] && !linkCfg.one.dataDirection;
  wire logic oneOnB = hitOne[1] && linkCfg.one.dataDirection;
  wire logic twoOnA = hitTwo[1] && !linkCfg.two.dataDirection;
  wire logic twoOnB = hitTwo[1] && linkCfg.two.dataDirection;
  wire logic txBitOne = linkTxOne[vsdp_bit_index(linkCfg.one.linear,
                                                 hitOne[0], bitInSlot)];
  wire logic txBitTwo = linkTxTwo[vsdp_bit_index(linkCfg.two.linear,
                                                 hitTwo[0], bitInSlot)];
  wire logic [3:0] bitDown = 4'(bitLeft - 4'h1);

  always_comb begin
    next_txState = txState;
    next_bitLeft = bitLeft;
    next_txStrobe = txStrobe;
    next_dataLineAOut = dataLineAOut;
    next_dataLineAOe = dataLineAOe;
    next_dataLineBOut = 1'b0;
    next_dataLineBOe = 1'b0;
    if (!linkCfg.port.enable) begin
      next_txState = TX_IDLE;
      next_txStrobe = 1'b0;
      next_dataLineAOut = 1'b0;
      next_dataLineAOe = 1'b0;
    end else if (!linkCfg.strobed) begin
      next_txState = TX_IDLE;
      next_txStrobe = 1'b0;
      next_dataLineBOut = dataLineBOut;
      next_dataLineBOe = dataLineBOe;
      if (driveNow) begin
        next_dataLineAOe = oneOnA || twoOnA;
        next_dataLineAOut = oneOnA ? txBitOne : (twoOnA & txBitTwo);
        next_dataLineBOe = oneOnB || twoOnB;
        next_dataLineBOut = oneOnB ? txBitOne : (twoOnB & txBitTwo);
      end
    end else begin
      case (txState)
        TX_IDLE: begin
          next_dataLineAOe = 1'b0;
          next_dataLineAOut = 1'b0;
          if (startSeen) begin
            next_txState = TX_SEND;
            next_txStrobe = 1'b1;
            next_dataLineAOe = 1'b1;
            next_dataLineAOut = linkTxOne[STROBE_LAST];
            next_bitLeft = STROBE_LAST;
          end
        end
        TX_SEND: begin
          if (bitLeft == 4'h0) begin
            next_txState = TX_IDLE;
            next_txStrobe = 1'b0;
            next_dataLineAOe = 1'b0;
            next_dataLineAOut = 1'b0;
          end else begin
            next_dataLineAOut = linkTxOne[bitDown];
            next_bitLeft = bitDown;
          end
        end
        default: begin
          next_txState = TX_IDLE;
          next_txStrobe = 1'b0;
          next_dataLineAOe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge bitClock or negedge rstn) begin
    if (!rstn) begin
      txState <= TX_IDLE;
      bitLeft <= 4'h0;
      fsTogP <= 1'b0;
      txStrobe <= 1'b0;
    end else begin
      txState <= next_txState;
      bitLeft <= next_bitLeft;
      fsTogP <= fsTogN;
      txStrobe <= next_txStrobe;
    end
  end

  always_ff @(posedge bitClock or negedge rstn) begin
    if (!rstn) begin
      dataLineAOut <= 1'b0;
      dataLineAOe <= 1'b0;
      dataLineBOut <= 1'b0;
      dataLineBOe <= 1'b0;
    end else begin
      dataLineAOut <= next_dataLineAOut;
      dataLineAOe <= next_dataLineAOe;
      dataLineBOut <= next_dataLineBOut;
      dataLineBOe <= next_dataLineBOe;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks

  sequence strobeSixteen;
    txStrobe [*8] ##1 txStrobe [*8];
  endsequence

  sequence strobeStart;
    $rose(txStrobe);
  endsequence

  AST_STROBE_LEN: assert property (
    @(posedge bitClock) disable iff (!rstn)
    strobeStart |-> strobeSixteen ##1 !txStrobe)
    else $error("transmit strobe not sixteen clocks");

  AST_FIRST_BIT: assert property (
    @(posedge bitClock) disable iff (!rstn)
    strobeStart |-> dataLineAOut == linkTxOne[15] && dataLineAOe)
    else $error("first strobed bit is not bit 15");

  AST_STROBE_END: assert property (
    @(posedge bitClock) disable iff (!rstn)
    $fell(txStrobe) |-> !dataLineAOe && $past(bitLeft) == 4'h0)
    else $error("strobe dropped at wrong time");

  AST_DRIVE_UNDER_STROBE: assert property (
    @(posedge bitClock) disable iff (!rstn)
    (linkCfg.strobed && $past(linkCfg.strobed)) |->
      (dataLineAOe == txStrobe))
    else $error("strobed line driven without strobe");

  AST_ONE_IFACE: assert property (
    @(posedge bitClock) disable iff (!rstn)
    $past(linkCfg.strobed) |-> !dataLineBOe)
    else $error("slot line driven in strobed mode");

  AST_DISABLED_QUIET: assert property (
    @(posedge bitClock) disable iff (!rstn)
    !linkCfg.port.enable |=> !dataLineAOe && !dataLineBOe && !txStrobe)
    else $error("lines driven while disabled");

  AST_DOUBLE_HOLD: assert property (
    @(posedge bitClock) disable iff (!rstn)
    (slotActive && dbl && cnt[0]) |=>
      $stable(dataLineAOut) && $stable(dataLineBOut))
    else $error("double clock bit changed on second clock");

  AST_SLOT_RANGE: assert property (
    @(posedge bitClock) disable iff (!rstn)
    (dataLineAOe && $past(slotActive)) |-> $past(slotInRange))
    else $error("slot line driven outside frame slots");

  AST_PULSE_RESET: assert property (
    @(negedge bitClock) disable iff (!rstn)
    fsRise |=> pulseNum <= 5'h01)
    else $error("pulse count not restarted at frame");

  AST_FRAME_RESTART: assert property (
    @(negedge bitClock) disable iff (!rstn)
    fsRise |=> cnt == CNT_W'(1))
    else $error("slot counter not restarted at frame");

endmodule

`default_nettype wire

// ===== verification/vsdp_far_end.sv
/*
 Far-end model of the voice port: bit clock, frame sync, receive strobes,
 line drive, and a record of the last whole frame seen on both lines.
 Assumes the bench resolves each line from the port's enable, taking this model's drive otherwise.
*/
`timescale 1ns/10ps
`default_nettype none

module vsdp_far_end #(
  parameter logic [63:0] PAT_A = 64'h3c96_e14b_a5d2_7f08,
  parameter logic [63:0] PAT_B = 64'h9a61_c7e2_05bd_48f3
) (
  output logic bitClock,
  output logic frameSync,
  output logic rxStrobe,
  output logic drvA,
  output logic drvB,
  input wire logic lineA,
  input wire logic lineB,
  input wire logic oeA,
  input wire logic oeB,
  input wire logic txStrobe,
  output int frames,
  output logic [63:0] lastA,
  output logic [63:0] lastB,
  output logic [63:0] lastOeA,
  output logic [63:0] lastOeB,
  output logic [63:0] lastStb
);
  int cyc = 63;
  logic [63:0] curA, curB, curOeA, curOeB, curStb;

  // free running, as a time-slot bus clock is; frame is 64 clocks
  initial begin
    {frameSync, rxStrobe, drvA, drvB} = 4'h0;
    frames = 0;
    bitClock = 1'b0;
    #7;
    forever #32 bitClock = ~bitClock;
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge bitClock) begin
    cyc = (cyc + 1) % 64;
    frameSync <= (cyc == 0);
    // two pulses of 16 clocks, low at the sync rise
    rxStrobe <= (cyc >= 4 && cyc < 20) || (cyc >= 24 && cyc < 40);
    drvA <= PAT_A[cyc];
    drvB <= PAT_B[cyc];
  end

  always @(negedge bitClock) begin
    curA[cyc] = lineA;
    curB[cyc] = lineB;
    curOeA[cyc] = oeA;
    curOeB[cyc] = oeB;
    curStb[cyc] = txStrobe;
    if (cyc == 63) begin
      {lastA, lastB, lastOeA} <= {curA, curB, curOeA};
      {lastOeB, lastStb} <= {curOeB, curStb};
      frames <= frames + 1;
    end
  end
endmodule
`default_nettype wire

// ===== verification/tb.sv
/*
 Self-checking bench of the voice serial data port: configures each mode,
 lets frames run and compares line traffic and received words.
 Assumes the far-end model in vsdp_far_end and the package vsdp_pkg.
*/
`timescale 1ns/10ps
`default_nettype none

module tb;
  import vsdp_pkg::*;
  localparam logic [63:0] PA = 64'h3c96_e14b_a5d2_7f08;
  localparam logic [63:0] PB = 64'h9a61_c7e2_05bd_48f3;
  localparam logic [63:0] ALL = '1;
  localparam logic [63:0] ODD = 64'haaaa_aaaa_aaaa_aaaa;
  logic ref_clk, rstn, strobedSel, rxValid, txStrobe;
  logic [2:0] cfgWrite;
  logic [13:0] cfgData;
  logic [15:0] txWordOne, txWordTwo, rxWordOne, rxWordTwo;
  logic bitClock, frameSync, rxStrobe, drvA, drvB, lineA, lineB;
  logic aOut, aOe, bOut, bOe;
  logic [PORT_CFG_W-1:0] portCfg;
  logic [CHAN_ONE_W-1:0] oneCfg;
  logic [CHAN_TWO_W-1:0] twoCfg;
  logic [63:0] lastA, lastB, lastOeA, lastOeB, lastStb;
  int frames, v0;
  int nValid = 0;
  int mismatches = 0;
  int n_tests = 0;

  assign lineA = aOe ? aOut : drvA;
  assign lineB = bOe ? bOut : drvB;

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk)
    if (rxValid === 1'b1)
      nValid <= nValid + 1;

  vsdp_port uut (.ref_clk(ref_clk), .rstn(rstn), .bitClock(bitClock),
    .frameSync(frameSync), .strobedSel(strobedSel), .cfgWrite(cfgWrite),
    .cfgData(cfgData), .txWordOne(txWordOne), .txWordTwo(txWordTwo),
    .dataLineAIn(lineA), .dataLineAOut(aOut), .dataLineAOe(aOe),
    .dataLineBIn(lineB), .dataLineBOut(bOut), .dataLineBOe(bOe),
    .rxStrobe(rxStrobe), .txStrobe(txStrobe), .serialPortConfig(portCfg),
    .voiceChannelOneConfig(oneCfg), .voiceChannelTwoConfig(twoCfg),
    .rxWordOne(rxWordOne), .rxWordTwo(rxWordTwo), .rxValid(rxValid));

  vsdp_far_end far (.bitClock(bitClock), .frameSync(frameSync),
    .rxStrobe(rxStrobe), .drvA(drvA), .drvB(drvB), .lineA(lineA),
    .lineB(lineB), .oeA(aOe), .oeB(bOe), .txStrobe(txStrobe),
    .frames(frames), .lastA(lastA), .lastB(lastB), .lastOeA(lastOeA),
    .lastOeB(lastOeB), .lastStb(lastStb));

  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("tests %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check16(input string what, input logic [15:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic check64(input string what, input logic [63:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic expired(input string what);
    mismatches++;
    $display("unexpected timeout: waiting for %s", what);
    tally_and_finish();
  endtask

  // stream bit i of a word lands on the last clock of its bit period
  function automatic logic [63:0] place(input logic [15:0] w,
                                        input int nb, st, stp);
    logic [63:0] s;
    s = '0;
    for (int i = 0; i < nb; i++)
      s[st + i * stp + stp - 1] = w[nb - 1 - i];
    return s;
  endfunction

  function automatic logic [15:0] pick(input logic [63:0] p,
                                       input int nb, st, stp);
    logic [15:0] w;
    w = '0;
    for (int i = 0; i < nb; i++)
      w[nb - 1 - i] = p[st + i * stp + stp - 1];
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  task automatic write_reg(input int r, input logic [13:0] d);
    @(negedge ref_clk);
    cfgWrite = 3'(1 << r);
    cfgData = d;
    @(negedge ref_clk);
    cfgWrite = 3'h0;
    @(negedge ref_clk);
  endtask

  task automatic configure(input vsdp_port_cfg_t p,
                           input vsdp_chan_cfg_t c1, c2);
    write_reg(REG_PORT, 14'(p));
    write_reg(REG_CHAN_ONE, c1);
    write_reg(REG_CHAN_TWO, c2);
    check16("serialPortConfig", 16'(p), 16'(portCfg));
    check16("voiceChannelOneConfig", 16'(c1), 16'(oneCfg));
    check16("voiceChannelTwoConfig", 16'(c2[9:0]), 16'(twoCfg));
  endtask

  task automatic wait_valid(input int n);
    int seen;
    seen = 0;
    for (int i = 0; i < 5000 && seen < n; i++) begin
      @(negedge ref_clk);
      if (rxValid === 1'b1)
        seen++;
    end
    if (seen < n)
      expired("rxValid");
  endtask

  task automatic wait_frames(input int n);
    int f0;
    f0 = frames;
    for (int i = 0; i < 2000 && frames < f0 + n; i++)
      @(negedge ref_clk);
    if (frames < f0 + n)
      expired("frames");
  endtask

  // new settings reach the link two or three frames on; five is safe
  task automatic check_frame(input logic [63:0] eOeA, eA, eOeB, eB, eStb,
      smpA, smpB, input logic [15:0] eR1, eR2, input bit chk2);
    wait_valid(5);
    check16("rxWordOne", eR1, rxWordOne);
    if (chk2)
      check16("rxWordTwo", eR2, rxWordTwo);
    check64("lineA enable", eOeA, lastOeA & smpA);
    check64("lineA data", eA, lastA & eOeA);
    check64("lineB enable", eOeB, lastOeB & smpB);
    check64("lineB data", eB, lastB & eOeB);
    check64("txStrobe", eStb, lastStb);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rstn = 1'b0;
    strobedSel = 1'b0;
    cfgWrite = 3'h0;
    cfgData = 14'h0000;
    txWordOne = 16'hc35a;
    txWordTwo = 16'h5ea7;
    repeat (4) @(negedge ref_clk);
    rstn = 1'b1;
    check16("serialPortConfig", 16'(PORT_CFG_RST), 16'(portCfg));
    check16("voiceChannelOneConfig", 16'(CHAN_CFG_RST), 16'(oneCfg));
    check16("voiceChannelTwoConfig", 16'h0000, 16'(twoCfg));
    // single clock: linear pair on A, companded slot on B
    configure({1'h1, 1'h0, 6'h08}, {4'h0, 1'h0, 1'h1, 1'h0, 6'h02, 1'h1},
      {4'h0, 1'h1, 1'h0, 1'h1, 6'h05, 1'h1});
    check_frame(place(16'hffff, 16, 16, 1), place(txWordOne, 16, 16, 1),
      place(16'hffff, 8, 40, 1), place(txWordTwo, 8, 40, 1), '0, ALL, ALL,
      pick(PB, 16, 16, 1), pick(PA, 8, 40, 1), 1'b1);
    // double clock: channel two sits past the slot count
    configure({1'h1, 1'h1, 6'h04}, {4'h0, 1'h0, 1'h0, 1'h1, 6'h00, 1'h1},
      {4'h0, 1'h0, 1'h1, 1'h0, 6'h04, 1'h1});
    check_frame('0, '0, place(16'hffff, 8, 0, 2), place(txWordOne, 8, 0, 2),
      '0, ALL, ODD, pick(PA, 8, 0, 2), '0, 1'b0);
    // strobed: listen to the second receive pulse
    strobedSel = 1'b1;
    txWordOne = 16'h81e6;
    configure({1'h1, 1'h0, 6'h08}, {4'h1, 1'h0, 1'h0, 1'h0, 6'h00, 1'h1},
      14'h0000);
    check_frame(place(16'hffff, 16, 1, 1), place(txWordOne, 16, 1, 1),
      '0, '0, place(16'hffff, 16, 1, 1), ALL, ALL, pick(PB, 16, 24, 1), '0,
      1'b0);
    // interface disabled: silent lines, no frame reports
    configure({1'h0, 1'h0, 6'h08}, 14'h0001, 14'h0001);
    wait_frames(4);
    v0 = nValid;
    wait_frames(2);
    check16("rxValid pulses", 16'h0000, 16'(nValid - v0));
    check64("lineA enable", '0, lastOeA);
    check64("lineB enable", '0, lastOeB);
    check64("txStrobe", '0, lastStb);
    tally_and_finish();
  end
endmodule
`default_nettype wire
